// *** dpwcl_consts.vh ***
`ifndef DPWCL_CONSTS_VH
`define DPWCL_CONSTS_VH
// device type field expected in the address byte; value is arbitrary
`define DPWCL_DEV_TYPE 4'h9
// opcodes, upper nibble of the instruction byte
`define DPWCL_OP_RD_WIPER 4'h9
`define DPWCL_OP_WR_WIPER 4'ha
`define DPWCL_OP_RD_SET 4'hb
`define DPWCL_OP_WR_SET 4'hc
`define DPWCL_OP_SET_TO_WIPER 4'hd
`define DPWCL_OP_WIPER_TO_SET 4'he
`define DPWCL_OP_G_SET_TO_WIPER 4'h1
`define DPWCL_OP_G_WIPER_TO_SET 4'h8
`define DPWCL_OP_INC_DEC 4'h2
// instruction byte field positions
`define DPWCL_OP_MSB 7
`define DPWCL_OP_LSB 4
`define DPWCL_SLOT_HI 3
`define DPWCL_SLOT_LO 2
`define DPWCL_POT_BIT 0
// timing: nonvolatile write time in us, wiper settle delay in ns, clock period in ns
`define DPWCL_NV_WRITE_US 10000
`define DPWCL_SETTLE_NS 1000
`define DPWCL_CLK_NS 50
// nv write rounds down (at most the time), settle rounds up (at least the time)
`define DPWCL_NV_WRITE_CYC ((`DPWCL_NV_WRITE_US * 1000) / `DPWCL_CLK_NS)
`define DPWCL_SETTLE_CYC ((`DPWCL_SETTLE_NS + `DPWCL_CLK_NS - 1) / `DPWCL_CLK_NS)
// power-up contents of every stored setting
`define DPWCL_SET_INIT 8'h80
`endif

// *** dpwcl_core.v ***
// Behaviour
// - two independent wiper position registers
// - 8-bit wiper decoded to one of 256 taps
// - write-wiper command loads wiper directly
// - wiper parallel-loads from any of four settings
// - increment or decrement moves one step
// - power-up loads wiper from slot zero
// - wiper registers are volatile
// - four 8-bit stored settings per pot
// - transfers both ways setting and wiper
// - setting change is nv write, 10 ms
// - all eight setting bits hold value
// - read/write wiper/setting are three-byte commands
// - wiper output updates after settle delay
// - wiper-to-setting takes nv write time
// - single or global transfers
// - transfer commands are two bytes only
// - single setting-to-wiper copies selected slot
// - global setting-to-wiper for every pot
// - global wiper-to-setting for every pot
// - after inc/dec ack each pulse steps
// - clock pulse with data high steps up
// - clock pulse with data low steps down
// - instruction: opcode, slot, zero, pot bit
// - nine opcodes decoded
// - ack address, instruction and data byte
// - no address ack while nv write busy
`timescale 1ns/1ns
`include "dpwcl_consts.vh"
module dpwcl_core #(
   parameter NV_WRITE_CYC = `DPWCL_NV_WRITE_CYC
) (
   // clock, reset, enable
   input wire ref_clk,
   input wire rst_n,
   input wire clk_en,
   // two-wire bus
   input wire scl_in,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe_n,
   // strap address pins
   input wire [3:0] strap_address_pins,
   // tap selects to the resistor arrays
   output reg [255:0] tap_sel0,
   output reg [255:0] tap_sel1,
   output reg [7:0] wiper_out0,
   output reg [7:0] wiper_out1,
   output reg nv_busy
);
   localparam S_IDLE = 6'h01;
   localparam S_ADDR = 6'h02;
   localparam S_INST = 6'h04;
   localparam S_DATA = 6'h08;
   localparam S_INCD = 6'h10;
   localparam S_SKIP = 6'h20;

   // pin synchronisers
   reg scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
   // storage
   reg [7:0] wiper_position_reg [0:1];
   reg [7:0] stored_setting_reg [0:7];
   // protocol state
   reg [5:0] state;
   reg [3:0] bit_cnt;
   reg [7:0] shreg;
   reg [7:0] inst;
   reg is_read;
   reg ack_phase;
   reg ack_drive;
   reg [31:0] nv_cnt;
   reg [7:0] settle_cnt;
   reg powered;
   reg [2:0] pu_cnt;
   integer i;

   wire scl_rise = scl_s2 & ~scl_d;
   wire scl_fall = ~scl_s2 & scl_d;
   wire start_c = scl_s2 & scl_d & sda_d & ~sda_s2;
   wire stop_c = scl_s2 & scl_d & ~sda_d & sda_s2;
   wire [3:0] op = inst[`DPWCL_OP_MSB:`DPWCL_OP_LSB];
   wire pot = inst[`DPWCL_POT_BIT];
   wire [1:0] slot = {inst[`DPWCL_SLOT_HI], inst[`DPWCL_SLOT_LO]};
   wire [2:0] sidx = {pot, slot};
   wire [3:0] op_n = shreg[6:3];
   wire [7:0] byte_in = {shreg[6:0], sda_s2};
   wire [3:0] next_op = byte_in[`DPWCL_OP_MSB:`DPWCL_OP_LSB];
   wire op_ok = (next_op == `DPWCL_OP_RD_WIPER) | (next_op == `DPWCL_OP_WR_WIPER) |
      (next_op == `DPWCL_OP_RD_SET) | (next_op == `DPWCL_OP_WR_SET) |
      (next_op == `DPWCL_OP_SET_TO_WIPER) | (next_op == `DPWCL_OP_WIPER_TO_SET) |
      (next_op == `DPWCL_OP_G_SET_TO_WIPER) | (next_op == `DPWCL_OP_G_WIPER_TO_SET) |
      (next_op == `DPWCL_OP_INC_DEC);
   wire [7:0] rd_val = (op == `DPWCL_OP_RD_WIPER) ? wiper_position_reg[pot] :
      stored_setting_reg[sidx];

   always @(posedge ref_clk) begin
      if (!rst_n) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_d <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_d <= 1'b1;
      end else if (clk_en) begin
         scl_s1 <= scl_in;
         scl_s2 <= scl_s1;
         scl_d <= scl_s2;
         sda_s1 <= sda_in;
         sda_s2 <= sda_s1;
         sda_d <= sda_s2;
      end
   end

   always @(posedge ref_clk) begin
      if (!rst_n) begin
         state <= S_IDLE;
         bit_cnt <= 4'h0;
         shreg <= 8'h00;
         inst <= 8'h00;
         is_read <= 1'b0;
         ack_phase <= 1'b0;
         ack_drive <= 1'b0;
         nv_cnt <= 32'h0;
         nv_busy <= 1'b0;
         sda_out <= 1'b1;
         sda_oe_n <= 1'b1;
         powered <= 1'b0;
         pu_cnt <= 3'h0;
         wiper_position_reg[0] <= 8'h00;
         wiper_position_reg[1] <= 8'h00;
         // reset stands for power loss: settings keep their contents
      end else if (clk_en) begin
         if (!powered) begin
            // power-up recall from slot zero
            wiper_position_reg[0] <= stored_setting_reg[0];
            wiper_position_reg[1] <= stored_setting_reg[4];
            powered <= 1'b1;
         end
         if (nv_busy) begin
            if (nv_cnt == 32'h0) begin
               nv_busy <= 1'b0;
            end else begin
               nv_cnt <= nv_cnt - 32'h1;
            end
         end
         if (start_c) begin
            state <= S_ADDR;
            is_read <= 1'b0;
            bit_cnt <= 4'h0;
            ack_phase <= 1'b0;
            ack_drive <= 1'b0;
            sda_oe_n <= 1'b1;
         end else if (stop_c) begin
            state <= S_IDLE;
            sda_oe_n <= 1'b1;
            // reads and wiper loads leave the nv array alone
            if (state == S_SKIP && (op == `DPWCL_OP_WR_SET ||
               op == `DPWCL_OP_WIPER_TO_SET || op == `DPWCL_OP_G_WIPER_TO_SET)) begin
               // nv writes begin at stop
               nv_busy <= 1'b1;
               nv_cnt <= NV_WRITE_CYC - 1;
               if (op == `DPWCL_OP_WR_SET) begin
                  stored_setting_reg[sidx] <= shreg;
               end else if (op == `DPWCL_OP_WIPER_TO_SET) begin
                  stored_setting_reg[sidx] <= wiper_position_reg[pot];
               end else begin
                  stored_setting_reg[{1'b0, slot}] <= wiper_position_reg[0];
                  stored_setting_reg[{1'b1, slot}] <= wiper_position_reg[1];
               end
            end
         end else begin
            case (state)
               S_IDLE: begin
                  sda_oe_n <= 1'b1;
               end
               S_ADDR, S_INST, S_DATA: begin
                  if (scl_rise && !ack_phase && !(is_read && state == S_DATA)) begin
                     shreg <= byte_in;
                     bit_cnt <= bit_cnt + 4'h1;
                  end
                  if (scl_fall && !ack_phase && is_read && state == S_DATA) begin
                     sda_out <= shreg[7];
                     sda_oe_n <= 1'b0;
                     shreg <= {shreg[6:0], 1'b0};
                     bit_cnt <= bit_cnt + 4'h1;
                     if (bit_cnt == 4'h7) begin
                        ack_phase <= 1'b1;
                     end
                  end else if (scl_fall && !ack_phase && bit_cnt == 4'h8) begin
                     ack_phase <= 1'b1;
                     sda_out <= 1'b0;
                     if (state == S_ADDR) begin
                        ack_drive <= (shreg[7:4] == `DPWCL_DEV_TYPE) &&
                           (shreg[3:0] == strap_address_pins) && !nv_busy;
                        sda_oe_n <= ~((shreg[7:4] == `DPWCL_DEV_TYPE) &&
                           (shreg[3:0] == strap_address_pins) && !nv_busy);
                     end else begin
                        ack_drive <= 1'b1;
                        sda_oe_n <= 1'b0;
                     end
                  end else if (scl_fall && ack_phase) begin
                     ack_phase <= 1'b0;
                     bit_cnt <= 4'h0;
                     sda_oe_n <= 1'b1;
                     sda_out <= 1'b1;
                     if (!ack_drive && !is_read) begin
                        state <= S_IDLE;
                     end else if (state == S_ADDR) begin
                        state <= S_INST;
                        is_read <= 1'b0;
                     end else if (state == S_INST) begin
                        inst <= shreg;
                        case (op_n)
                           4'h0: state <= S_IDLE;
                           default: state <= S_IDLE;
                        endcase
                        if (shreg[7:4] == `DPWCL_OP_RD_WIPER ||
                           shreg[7:4] == `DPWCL_OP_RD_SET) begin
                           state <= S_DATA;
                           is_read <= 1'b1;
                           sda_out <= (shreg[7:4] == `DPWCL_OP_RD_WIPER) ?
                              wiper_position_reg[shreg[0]][7] :
                              stored_setting_reg[{shreg[0], shreg[3:2]}][7];
                           sda_oe_n <= 1'b0;
                           shreg <= (shreg[7:4] == `DPWCL_OP_RD_WIPER) ?
                              {wiper_position_reg[shreg[0]][6:0], 1'b0} :
                              {stored_setting_reg[{shreg[0], shreg[3:2]}][6:0], 1'b0};
                           bit_cnt <= 4'h1;
                        end else if (shreg[7:4] == `DPWCL_OP_WR_WIPER ||
                           shreg[7:4] == `DPWCL_OP_WR_SET) begin
                           state <= S_DATA;
                        end else if (shreg[7:4] == `DPWCL_OP_INC_DEC) begin
                           state <= S_INCD;
                        end else if (shreg[7:4] == `DPWCL_OP_SET_TO_WIPER) begin
                           wiper_position_reg[shreg[0]] <=
                              stored_setting_reg[{shreg[0], shreg[3:2]}];
                           state <= S_SKIP;
                           inst <= 8'h00;
                        end else if (shreg[7:4] == `DPWCL_OP_G_SET_TO_WIPER) begin
                           wiper_position_reg[0] <= stored_setting_reg[{1'b0, shreg[3:2]}];
                           wiper_position_reg[1] <= stored_setting_reg[{1'b1, shreg[3:2]}];
                           state <= S_SKIP;
                           inst <= 8'h00;
                        end else begin
                           // wiper-to-setting transfers commit at stop
                           state <= S_SKIP;
                        end
                     end else begin
                        if (!is_read) begin
                           if (op == `DPWCL_OP_WR_WIPER) begin
                              wiper_position_reg[pot] <= shreg;
                              inst <= 8'h00;
                           end else begin
                              inst <= inst;
                           end
                        end
                        state <= S_SKIP;
                     end
                  end
               end
               S_INCD: begin
                  // count a completed pulse: start and stop never end one here
                  if (scl_fall) begin
                     if (sda_d && wiper_position_reg[pot] != 8'hff) begin
                        wiper_position_reg[pot] <= wiper_position_reg[pot] + 8'h01;
                     end else if (!sda_d && wiper_position_reg[pot] != 8'h00) begin
                        wiper_position_reg[pot] <= wiper_position_reg[pot] - 8'h01;
                     end
                  end
               end
               S_SKIP: begin
                  sda_oe_n <= 1'b1;
               end
               default: state <= S_IDLE;
            endcase
         end
      end
   end

   // stored settings: power-up contents, nv array not cleared by reset
   initial begin
      for (i = 0; i < 8; i = i + 1) begin
         stored_setting_reg[i] = `DPWCL_SET_INIT;
      end
   end

   // wiper output follows after settle delay
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         settle_cnt <= 8'h00;
         wiper_out0 <= 8'h00;
         wiper_out1 <= 8'h00;
         tap_sel0 <= 256'h0;
         tap_sel1 <= 256'h0;
      end else if (clk_en) begin
         if (wiper_out0 != wiper_position_reg[0] || wiper_out1 != wiper_position_reg[1]) begin
            if (settle_cnt == `DPWCL_SETTLE_CYC - 1) begin
               settle_cnt <= 8'h00;
               wiper_out0 <= wiper_position_reg[0];
               wiper_out1 <= wiper_position_reg[1];
               tap_sel0 <= 256'h1 << wiper_position_reg[0];
               tap_sel1 <= 256'h1 << wiper_position_reg[1];
            end else begin
               settle_cnt <= settle_cnt + 8'h01;
            end
         end else begin
            settle_cnt <= 8'h00;
            tap_sel0 <= 256'h1 << wiper_out0;
            tap_sel1 <= 256'h1 << wiper_out1;
         end
      end
   end
endmodule // dpwcl_core

// *** dpwcl_core_asserts.sv ***
`timescale 1ns/1ns
module dpwcl_core_asserts #(
   parameter NV_WRITE_CYC = 20
) (
   // clock and reset
   input wire ref_clk,
   input wire rst_n,
   // bus pins
   input wire scl_in,
   input wire sda_in,
   input wire sda_oe_n,
   // wiper side
   input wire [255:0] tap_sel0,
   input wire [255:0] tap_sel1,
   input wire [7:0] wiper_out0,
   input wire nv_busy
);
   default clocking dc @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // busy length, and cycles since pot 0 tap last moved
   logic [15:0] busy_cnt;
   logic [4:0] quiet;
   logic [255:0] tap_q;
   always @(posedge ref_clk) begin
      tap_q <= tap_sel0;
      busy_cnt <= (rst_n && nv_busy) ? busy_cnt + 16'd1 : 16'd0;
      quiet <= (!rst_n || tap_sel0 != tap_q) ? 5'd0 : (quiet == 5'd31 ? quiet : quiet + 5'd1);
   end
   tap_onehot_a: assert property ($onehot0(tap_sel0) && $onehot0(tap_sel1))
      else $error("tap select not one-hot");
   wiper_reload_a: assert property ($rose(rst_n) |-> ##[1:30] (tap_sel0 != 0 && tap_sel1 != 0))
      else $error("no wiper reload after reset");
   busy_no_ack_a: assert property (nv_busy |-> sda_oe_n)
      else $error("sda driven while busy");
   busy_len_a: assert property ($fell(nv_busy) |-> busy_cnt + 1 >= NV_WRITE_CYC && busy_cnt <= NV_WRITE_CYC + 1)
      else $error("busy length wrong");
   busy_at_stop_a: assert property ($rose(nv_busy) |-> scl_in && sda_in)
      else $error("busy not started by stop");
   // sync delay lets a change land just after the rise
   sda_scl_low_a: assert property (!$stable(sda_oe_n) |-> !(scl_in && $past(scl_in, 3)))
      else $error("sda changed in scl high");
   busy_hold_a: assert property (nv_busy |=> $stable(tap_sel0) && $stable(tap_sel1))
      else $error("wiper moved while busy");
   settle_match_a: assert property (quiet == 5'd30 |-> tap_sel0 == (256'd1 << wiper_out0))
      else $error("wiper output not settled");
endmodule // dpwcl_core_asserts
bind dpwcl_core dpwcl_core_asserts #(.NV_WRITE_CYC(NV_WRITE_CYC)) dpwcl_core_asserts_i (
   .ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_oe_n(sda_oe_n),
   .tap_sel0(tap_sel0), .tap_sel1(tap_sel1), .wiper_out0(wiper_out0), .nv_busy(nv_busy));

// *** dpwcl_mst.sv ***
`timescale 1ns/1ns
module dpwcl_mst (
   // clock
   input wire ref_clk,
   // bus lines
   input wire sda_line,
   output reg scl = 1'b1,
   output reg sda_drv = 1'b1
);
   // half bit in clocks; raised to stretch the bus
   int hlen = 4;
   task automatic half;
      repeat (hlen) @(posedge ref_clk);
   endtask
   // sda raised in scl low first, so also a repeated start
   task automatic start;
      sda_drv <= 1'b1;
      half;
      scl <= 1'b1;
      half;
      sda_drv <= 1'b0;
      half;
      scl <= 1'b0;
   endtask
   task automatic stop;
      sda_drv <= 1'b0;
      half;
      scl <= 1'b1;
      half;
      sda_drv <= 1'b1;
      half;
   endtask
   task automatic clk_bit(input logic b, output logic r);
      sda_drv <= b;
      half;
      scl <= 1'b1;
      half;
      r = sda_line;
      scl <= 1'b0;
   endtask
   task automatic send(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
      clk_bit(1'b1, r);
      ack = !r;
   endtask
   task automatic recv(output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
      clk_bit(1'b1, r);
   endtask
endmodule // dpwcl_mst

// *** test_dpwcl_core.sv ***
`timescale 1ns/1ns
`include "dpwcl_consts.vh"
module test_dpwcl_core;
   localparam logic [3:0] STRAP = 4'h6;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic clk_en = 1'b1;
   logic [3:0] strap = STRAP;
   logic [7:0] st [2][4];
   wire scl;
   wire sda_m;
   wire sda_oe_n;
   wire sda_out;
   wire [7:0] wiper_out0;
   // pull-up: a released line reads high
   wire sda = sda_m & (sda_oe_n | sda_out);
   int mismatches = 0;
   int compares = 0;
   int cycles = 0;
   always #25 ref_clk = ~ref_clk;
   dpwcl_mst dpwcl_mst_i (.ref_clk(ref_clk), .sda_line(sda), .scl(scl), .sda_drv(sda_m));
   dpwcl_core #(.NV_WRITE_CYC(400)) dpwcl_core_i (.ref_clk(ref_clk), .rst_n(rst_n),
      .clk_en(clk_en), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
      .strap_address_pins(strap), .tap_sel0(), .tap_sel1(), .wiper_out0(wiper_out0),
      .wiper_out1(), .nv_busy());
   task automatic stop_test;
      if (mismatches == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %0t byte %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %0t ack %b expected %b", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] ins(input logic [3:0] op, input logic [1:0] s, input logic p);
      return {op, s, 1'b0, p};
   endfunction
   // polls the address until acked; busy device stays silent
   task automatic open_dev;
      logic a;
      a = 1'b0;
      for (int n = 0; n < 40 && !a; n++) begin
         dpwcl_mst_i.start;
         dpwcl_mst_i.send({`DPWCL_DEV_TYPE, STRAP}, a);
      end
      chk1(a, 1'b1);
   endtask
   task automatic cmd(input logic [7:0] i, input logic [7:0] d, input bit three);
      logic a;
      open_dev;
      dpwcl_mst_i.send(i, a);
      chk1(a, 1'b1);
      if (three) dpwcl_mst_i.send(d, a);
      if (three) chk1(a, 1'b1);
      dpwcl_mst_i.stop;
   endtask
   task automatic rdc(input logic [7:0] i, input logic [7:0] exp);
      logic a;
      logic [7:0] d;
      open_dev;
      dpwcl_mst_i.send(i, a);
      chk1(a, 1'b1);
      dpwcl_mst_i.recv(d);
      dpwcl_mst_i.stop;
      chk8(d, exp);
   endtask
   // left in step mode; the next start ends it
   task automatic step(input logic up, input int n);
      logic a;
      logic r;
      open_dev;
      dpwcl_mst_i.send(ins(`DPWCL_OP_INC_DEC, 2'd0, 1'b0), a);
      chk1(a, 1'b1);
      repeat (n) dpwcl_mst_i.clk_bit(up, r);
   endtask
   task automatic do_reset;
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge ref_clk);
   endtask
   task automatic t_settings;
      logic a;
      for (int k = 0; k < 8; k++) begin
         st[k/4][k%4] = 8'h5b * k[7:0] ^ 8'hf0;
         cmd(ins(`DPWCL_OP_WR_SET, k[1:0], k[2]), st[k/4][k%4], 1'b1);
      end
      dpwcl_mst_i.start;
      dpwcl_mst_i.send({`DPWCL_DEV_TYPE, STRAP}, a);
      chk1(a, 1'b0);
      for (int k = 0; k < 8; k++)
         rdc(ins(`DPWCL_OP_RD_SET, k[1:0], k[2]), st[k/4][k%4]);
   endtask
   task automatic t_xfer;
      cmd(ins(`DPWCL_OP_WR_WIPER, 2'd0, 1'b1), 8'h3c, 1'b1);
      rdc(ins(`DPWCL_OP_RD_WIPER, 2'd0, 1'b0), `DPWCL_SET_INIT);
      cmd(ins(`DPWCL_OP_SET_TO_WIPER, 2'd2, 1'b0), 8'h00, 1'b0);
      rdc(ins(`DPWCL_OP_RD_WIPER, 2'd0, 1'b0), st[0][2]);
      rdc(ins(`DPWCL_OP_RD_WIPER, 2'd0, 1'b1), 8'h3c);
      cmd(ins(`DPWCL_OP_WIPER_TO_SET, 2'd3, 1'b1), 8'h00, 1'b0);
      rdc(ins(`DPWCL_OP_RD_SET, 2'd3, 1'b1), 8'h3c);
      cmd(ins(`DPWCL_OP_G_SET_TO_WIPER, 2'd1, 1'b0), 8'h00, 1'b0);
      rdc(ins(`DPWCL_OP_RD_WIPER, 2'd0, 1'b1), st[1][1]);
      cmd(ins(`DPWCL_OP_G_WIPER_TO_SET, 2'd0, 1'b0), 8'h00, 1'b0);
      rdc(ins(`DPWCL_OP_RD_SET, 2'd0, 1'b0), st[0][1]);
      rdc(ins(`DPWCL_OP_RD_SET, 2'd0, 1'b1), st[1][1]);
   endtask
   task automatic t_step;
      cmd(ins(`DPWCL_OP_WR_WIPER, 2'd0, 1'b0), 8'hfd, 1'b1);
      dpwcl_mst_i.hlen = 16;
      step(1'b1, 1);
      repeat (40) @(posedge ref_clk);
      chk8(wiper_out0, 8'hfe);
      dpwcl_mst_i.hlen = 4;
      step(1'b1, 3);
      rdc(ins(`DPWCL_OP_RD_WIPER, 2'd0, 1'b0), 8'hff);
      cmd(ins(`DPWCL_OP_WR_WIPER, 2'd0, 1'b0), 8'h02, 1'b1);
      step(1'b0, 4);
      dpwcl_mst_i.stop;
      rdc(ins(`DPWCL_OP_RD_WIPER, 2'd0, 1'b0), 8'h00);
   endtask
   task automatic t_addr;
      logic a;
      @(posedge ref_clk);
      strap <= ~STRAP;
      dpwcl_mst_i.start;
      dpwcl_mst_i.send({`DPWCL_DEV_TYPE, STRAP}, a);
      chk1(a, 1'b0);
      strap <= STRAP;
      dpwcl_mst_i.start;
      dpwcl_mst_i.send({~`DPWCL_DEV_TYPE, STRAP}, a);
      chk1(a, 1'b0);
      dpwcl_mst_i.stop;
   endtask
   // settings survive, wipers lose their value
   task automatic t_reset;
      do_reset;
      rdc(ins(`DPWCL_OP_RD_WIPER, 2'd0, 1'b0), st[0][1]);
      rdc(ins(`DPWCL_OP_RD_WIPER, 2'd0, 1'b1), st[1][1]);
   endtask
   initial begin
      do_reset;
      rdc(ins(`DPWCL_OP_RD_WIPER, 2'd0, 1'b1), `DPWCL_SET_INIT);
      t_settings;
      t_xfer;
      t_step;
      t_addr;
      t_reset;
      stop_test;
   end
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         mismatches++;
         stop_test;
      end
   end
endmodule // test_dpwcl_core
